// File: src/ramp_pkg.sv
// Constants and carriers for the ramp block.
// Assumes a 100 MHz clock and a simple strobe register port.
//
// Notes on behaviour
// - Accel time is the time from zero to the ramp reference frequency.
// - Decel time is the time from the ramp reference frequency to zero.
// - Resolution 0: 0.1 s steps to 3600 s; 1: 0.01 s steps to 360 s.
// - Changing resolution reinterprets stored times, scaling them by ten.
// - Restart accel time keeps its units whatever the resolution.
// - Second select active uses the second accel and decel times.
// - Third select active uses the third set, winning over the second.
// - Second or third decel of 9999 reuses the matching accel time.
// - Third accel of 9999 disables the third set entirely.
// - Third select comes from a terminal with function code 9.
// - Second select uses its own pin unless a terminal has code 3.
// - Under V/F or flux vector, times of 0.03 s or less run as 0.04 s.
// - S-pattern A: time refers to base; above it slope follows 4/9, 5/9 law.
// - Reference frequency changes leave command gain frequencies untouched.
// - Start begins the output at the starting frequency, 0 to 60 Hz.
// - No start while the frequency command is below starting frequency.
// - Start holds starting frequency for 0 to 10 s; 9999 disables the hold.
// - A starting frequency of zero is held as 0.01 Hz.
// - Start removed during the hold begins deceleration at once.
// - On reversal the starting frequency applies but the hold is skipped.
// - Starting freq at or below minimum runs on start alone, at minimum.

package ramp_pkg;

    // ----------------------------------------------------------------
    // Units: frequency in 0.01 Hz, times as raw settings
    // ----------------------------------------------------------------
    localparam logic [15:0] NOT_USED   = 16'h270F;
    localparam logic [15:0] TIME_MAX   = 16'h8CA0;
    localparam logic [15:0] HOLD_MAX   = 16'h0064;
    localparam logic [15:0] FREQ_MAX   = 16'h9C40;
    localparam logic [15:0] FREQ_LOW   = 16'h0064;
    localparam logic [15:0] START_MAX  = 16'h1770;
    localparam logic [15:0] FREQ_FLOOR = 16'h0001;
    localparam logic [23:0] MS_COARSE  = 24'h000064;
    localparam logic [23:0] MS_FINE    = 24'h00000A;
    localparam logic [23:0] FAST_LIMIT = 24'h00001E;
    localparam logic [23:0] FAST_FLOOR = 24'h000028;
    localparam logic [23:0] MS_MIN     = 24'h000001;
    localparam logic [7:0]  SA_NUM     = 8'h09;
    localparam logic [7:0]  SA_DEN     = 8'h08;

    // ----------------------------------------------------------------
    // Control tick timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_ACC   = 8'h04;
    localparam logic [7:0] A_DEC   = 8'h08;
    localparam logic [7:0] A_REF   = 8'h0C;
    localparam logic [7:0] A_ACC2  = 8'h10;
    localparam logic [7:0] A_DEC2  = 8'h14;
    localparam logic [7:0] A_ACC3  = 8'h18;
    localparam logic [7:0] A_DEC3  = 8'h1C;
    localparam logic [7:0] A_BASE  = 8'h20;
    localparam logic [7:0] A_MINF  = 8'h24;
    localparam logic [7:0] A_STRT  = 8'h28;
    localparam logic [7:0] A_HOLD  = 8'h2C;
    localparam logic [7:0] A_RSTA  = 8'h30;
    localparam logic [7:0] A_GAINA = 8'h34;
    localparam logic [7:0] A_GAINB = 8'h38;
    localparam logic [7:0] A_FREQ  = 8'h3C;
    localparam logic [7:0] A_STAT  = 8'h40;
    localparam logic [7:0] A_INJ   = 8'h44;
    localparam logic [7:0] A_TERM  = 8'h80;

    // Control register bits
    localparam int CTRL_RES = 0;
    localparam int CTRL_SA  = 1;
    localparam int CTRL_VF  = 2;
    localparam int CTRL_RST = 3;

    // Terminal function codes
    localparam logic [7:0] FUNC_SECOND = 8'h03;
    localparam logic [7:0] FUNC_THIRD  = 8'h09;
    localparam logic [7:0] FUNC_NONE   = 8'h00;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_TIME  = 16'h0032;
    localparam logic [15:0] RST_REF   = 16'h1770;
    localparam logic [15:0] RST_STRT  = 16'h0032;
    localparam logic [15:0] RST_GAIN  = 16'h1770;
    localparam logic [15:0] RST_INJ   = 16'h012C;

    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RUN} run_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } bus_req_s;

    typedef struct packed {
        logic [3:0]  ctrl;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] ref_f;
        logic [15:0] acc2;
        logic [15:0] dec2;
        logic [15:0] acc3;
        logic [15:0] dec3;
        logic [15:0] base;
        logic [15:0] minf;
        logic [15:0] startf;
        logic [15:0] hold;
        logic [15:0] rst_acc;
        logic [15:0] gain_a;
        logic [15:0] gain_b;
        logic [15:0] inj;
    } par_s;

endpackage

// File: src/freq_ramp.sv
// Frequency ramp with time set selection and start-time hold.
// Assumes start and select pins are asynchronous and the frequency
// command comes from logic on the same clock.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns

module freq_ramp #(
    parameter int N_TERM     = 12,
    parameter int TICK_COUNT = ramp_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    // Register port
    input  wire ramp_pkg::bus_req_s  bus_i,
    output logic [31:0]              rd_data_o,
    // Pins
    input  wire logic                start_fwd_i,
    input  wire logic                start_rev_i,
    input  wire logic                second_set_select_i,
    input  wire logic [N_TERM-1:0]   term_i,
    // Frequency command, 0.01 Hz
    input  wire logic [15:0]         freq_cmd_i,
    // Modulator side
    output logic [15:0]              ramp_freq_o,
    output logic                     ramp_dir_o,
    output logic                     running_o
);
    import ramp_pkg::*;

    localparam int NP = N_TERM + 3;

    initial begin
        if (N_TERM < 1 || N_TERM > 32 || TICK_COUNT < 2 || TICK_COUNT > 131071) begin
            $error("freq_ramp: unsupported parameter value");
        end
    end

    typedef struct packed {
        par_s                   par;
        logic [N_TERM*8-1:0]    fcode;
        logic [NP-1:0]          s1;
        logic [NP-1:0]          s2;
        logic [NP-1:0]          s3;
        logic [NP-1:0]          flt;
        logic [16:0]            tick_cnt;
        logic                   tick;
        logic [16:0]            hold_cnt;
        logic [47:0]            acc;
        logic [15:0]            freq;
        logic                   dir;
        run_e                   st;
        logic [31:0]            rdata;
    } state_s;

    state_s q_ff;
    state_s nxt_q;

    // ----------------------------------------------------------------
    // Combinational helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] clamp_time(input logic [15:0] v);
        clamp_time = (v > TIME_MAX && v != NOT_USED) ? TIME_MAX : v;
    endfunction

    // Raw setting to milliseconds
    function automatic logic [23:0] to_ms(input logic [15:0] raw,
                                          input logic       fine,
                                          input logic       vf);
        logic [23:0] ms;
        ms = {8'h00, raw} * (fine ? MS_FINE : MS_COARSE);
        if (vf && ms <= FAST_LIMIT) begin
            ms = FAST_FLOOR;
        end
        if (ms < MS_MIN) begin
            ms = MS_MIN;
        end
        to_ms = ms;
    endfunction

    logic [NP-1:0] pins;
    logic          fwd;
    logic          rev;
    logic          want_run;
    logic          want_dir;
    logic          any_code2;
    logic          sel2;
    logic          sel3;
    logic          use3;
    logic          use2;
    logic [15:0]   acc_raw;
    logic [15:0]   dec_raw;
    logic [23:0]   acc_ms;
    logic [23:0]   dec_ms;
    logic [23:0]   t_ms;
    logic [15:0]   start_eff;
    logic [15:0]   target;
    logic [47:0]   step_a;
    logic [47:0]   step_b;
    logic [47:0]   acc_sum;
    logic [16:0]   hold_lim;
    logic          start_ok;
    logic [15:0]   cmd_lim;

    assign pins = {second_set_select_i, start_rev_i, start_fwd_i, term_i};

    always_comb begin
        fwd      = q_ff.flt[N_TERM];
        rev      = q_ff.flt[N_TERM+1];
        want_run = fwd ^ rev;
        want_dir = rev;
        any_code2 = 1'b0;
        sel2      = 1'b0;
        sel3      = 1'b0;
        for (int i = 0; i < N_TERM; i++) begin
            if (q_ff.fcode[i*8 +: 8] == FUNC_SECOND) begin
                any_code2 = 1'b1;
                sel2      = sel2 | q_ff.flt[i];
            end
            if (q_ff.fcode[i*8 +: 8] == FUNC_THIRD) begin
                sel3 = sel3 | q_ff.flt[i];
            end
        end
        if (!any_code2) begin
            sel2 = q_ff.flt[N_TERM+2];
        end
        use3 = sel3 && (q_ff.par.acc3 != NOT_USED);
        use2 = sel2 && !use3;
        if (use3) begin
            acc_raw = q_ff.par.acc3;
            dec_raw = (q_ff.par.dec3 == NOT_USED) ? q_ff.par.acc3 : q_ff.par.dec3;
        end else if (use2) begin
            acc_raw = q_ff.par.acc2;
            dec_raw = (q_ff.par.dec2 == NOT_USED) ? q_ff.par.acc2 : q_ff.par.dec2;
        end else begin
            acc_raw = q_ff.par.accel;
            dec_raw = q_ff.par.decel;
        end
        acc_ms = to_ms(acc_raw, q_ff.par.ctrl[CTRL_RES], q_ff.par.ctrl[CTRL_VF]);
        dec_ms = to_ms(dec_raw, q_ff.par.ctrl[CTRL_RES], q_ff.par.ctrl[CTRL_VF]);
        if (q_ff.par.ctrl[CTRL_RST]) begin
            acc_ms = to_ms(q_ff.par.rst_acc, 1'b0, q_ff.par.ctrl[CTRL_VF]);
        end
        // zero start held as 0.01 Hz
        start_eff = (q_ff.par.startf == 16'h0000) ? FREQ_FLOOR : q_ff.par.startf;
        cmd_lim = (freq_cmd_i < q_ff.par.minf) ? q_ff.par.minf : freq_cmd_i;
        if (cmd_lim > FREQ_MAX) begin
            cmd_lim = FREQ_MAX;
        end
        start_ok = want_run && (freq_cmd_i >= q_ff.par.startf
                                || q_ff.par.startf <= q_ff.par.minf);
        // stop or reverse ramps to zero
        target = (want_run && want_dir == q_ff.dir) ? cmd_lim : 16'h0000;
        t_ms = (q_ff.freq < target) ? acc_ms : dec_ms;
        // above base: slope 9 fb^2 / (8 T f)
        if (q_ff.par.ctrl[CTRL_SA] && q_ff.freq >= q_ff.par.base) begin
            step_a = 48'({8'h00, q_ff.par.base} * q_ff.par.base * SA_NUM);
            step_b = 48'({24'h000000, t_ms} * q_ff.freq * SA_DEN);
        end else if (q_ff.par.ctrl[CTRL_SA]) begin
            step_a = 48'(q_ff.par.base);
            step_b = 48'(t_ms);
        end else begin
            step_a = 48'(q_ff.par.ref_f);
            step_b = 48'(t_ms);
        end
        acc_sum  = q_ff.tick ? q_ff.acc + step_a : q_ff.acc;
        hold_lim = 17'(q_ff.par.hold * MS_COARSE);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;

        // Pin filter: change counts once stages two and three agree
        nxt_q.s1  = pins;
        nxt_q.s2  = q_ff.s1;
        nxt_q.s3  = q_ff.s2;
        nxt_q.flt = (q_ff.s3 & ~(q_ff.s2 ^ q_ff.s3))
                  | (q_ff.flt & (q_ff.s2 ^ q_ff.s3));

        // Control tick divider
        nxt_q.tick = 1'b0;
        if (q_ff.tick_cnt == 17'(TICK_COUNT - 1)) begin
            nxt_q.tick_cnt = 17'h00000;
            nxt_q.tick     = 1'b1;
        end else begin
            nxt_q.tick_cnt = q_ff.tick_cnt + 17'h00001;
        end

        // Register writes
        if (bus_i.we) begin
            unique case (bus_i.addr)
                A_CTRL:  nxt_q.par.ctrl    = bus_i.wdata[3:0];
                A_ACC:   nxt_q.par.accel   = clamp_time(bus_i.wdata[15:0]);
                A_DEC:   nxt_q.par.decel   = clamp_time(bus_i.wdata[15:0]);
                A_ACC2:  nxt_q.par.acc2    = clamp_time(bus_i.wdata[15:0]);
                A_DEC2:  nxt_q.par.dec2    = clamp_time(bus_i.wdata[15:0]);
                A_ACC3:  nxt_q.par.acc3    = clamp_time(bus_i.wdata[15:0]);
                A_DEC3:  nxt_q.par.dec3    = clamp_time(bus_i.wdata[15:0]);
                A_BASE:  nxt_q.par.base    = bus_i.wdata[15:0];
                A_MINF:  nxt_q.par.minf    = bus_i.wdata[15:0];
                A_RSTA:  nxt_q.par.rst_acc = clamp_time(bus_i.wdata[15:0]);
                A_INJ:   nxt_q.par.inj     = bus_i.wdata[15:0];
                // gains stored apart from the reference
                A_GAINA: nxt_q.par.gain_a  = bus_i.wdata[15:0];
                A_GAINB: nxt_q.par.gain_b  = bus_i.wdata[15:0];
                A_REF: begin
                    nxt_q.par.ref_f = bus_i.wdata[15:0];
                    if (bus_i.wdata[15:0] < FREQ_LOW) begin
                        nxt_q.par.ref_f = FREQ_LOW;
                    end else if (bus_i.wdata[15:0] > FREQ_MAX) begin
                        nxt_q.par.ref_f = FREQ_MAX;
                    end
                end
                // start frequency limited to 60 Hz
                A_STRT: begin
                    nxt_q.par.startf = (bus_i.wdata[15:0] > START_MAX)
                                     ? START_MAX : bus_i.wdata[15:0];
                end
                // hold limited to 10 s or disabled
                A_HOLD: begin
                    nxt_q.par.hold = (bus_i.wdata[15:0] > HOLD_MAX
                                      && bus_i.wdata[15:0] != NOT_USED)
                                   ? HOLD_MAX : bus_i.wdata[15:0];
                end
                default: begin
                    for (int i = 0; i < N_TERM; i++) begin
                        if (bus_i.addr == 8'(A_TERM + 8'(i * 4))) begin
                            nxt_q.fcode[i*8 +: 8] = bus_i.wdata[7:0];
                        end
                    end
                end
            endcase
        end

        // Register reads, answer in the next cycle
        nxt_q.rdata = 32'h00000000;
        if (bus_i.re) begin
            unique case (bus_i.addr)
                A_CTRL:  nxt_q.rdata = 32'(q_ff.par.ctrl);
                A_ACC:   nxt_q.rdata = 32'(q_ff.par.accel);
                A_DEC:   nxt_q.rdata = 32'(q_ff.par.decel);
                A_REF:   nxt_q.rdata = 32'(q_ff.par.ref_f);
                A_ACC2:  nxt_q.rdata = 32'(q_ff.par.acc2);
                A_DEC2:  nxt_q.rdata = 32'(q_ff.par.dec2);
                A_ACC3:  nxt_q.rdata = 32'(q_ff.par.acc3);
                A_DEC3:  nxt_q.rdata = 32'(q_ff.par.dec3);
                A_BASE:  nxt_q.rdata = 32'(q_ff.par.base);
                A_MINF:  nxt_q.rdata = 32'(q_ff.par.minf);
                A_STRT:  nxt_q.rdata = 32'(q_ff.par.startf);
                A_HOLD:  nxt_q.rdata = 32'(q_ff.par.hold);
                A_RSTA:  nxt_q.rdata = 32'(q_ff.par.rst_acc);
                A_GAINA: nxt_q.rdata = 32'(q_ff.par.gain_a);
                A_GAINB: nxt_q.rdata = 32'(q_ff.par.gain_b);
                A_INJ:   nxt_q.rdata = 32'(q_ff.par.inj);
                A_FREQ:  nxt_q.rdata = 32'(q_ff.freq);
                A_STAT: begin
                    nxt_q.rdata = {26'h0000000, use3, use2, q_ff.dir,
                                   want_run, 2'(q_ff.st)};
                end
                default: begin
                    for (int i = 0; i < N_TERM; i++) begin
                        if (bus_i.addr == 8'(A_TERM + 8'(i * 4))) begin
                            nxt_q.rdata = 32'(q_ff.fcode[i*8 +: 8]);
                        end
                    end
                end
            endcase
        end

        // ------------------------------------------------------------
        // Run sequence
        // ------------------------------------------------------------
        unique case (q_ff.st)
            ST_IDLE: begin
                nxt_q.freq = 16'h0000;
                nxt_q.acc  = '0;
                if (start_ok) begin
                    nxt_q.freq     = start_eff;
                    nxt_q.dir      = want_dir;
                    nxt_q.hold_cnt = '0;
                    nxt_q.st = (q_ff.par.hold == NOT_USED) ? ST_RUN : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!want_run || want_dir != q_ff.dir) begin
                    nxt_q.st = ST_RUN;
                end else if (q_ff.hold_cnt >= hold_lim) begin
                    nxt_q.st = ST_RUN;
                end else if (q_ff.tick) begin
                    nxt_q.hold_cnt = q_ff.hold_cnt + 17'h1;
                end
            end
            ST_RUN: begin
                if (q_ff.freq == target) begin
                    nxt_q.acc = '0;
                    if (target == 16'h0000) begin
                        if (want_run) begin
                            nxt_q.freq = start_eff;
                            nxt_q.dir  = want_dir;
                        end else begin
                            nxt_q.st = ST_IDLE;
                        end
                    end
                end else if (acc_sum >= step_b) begin
                    // one 0.01 Hz step per earned quantum
                    nxt_q.acc  = acc_sum - step_b;
                    nxt_q.freq = (q_ff.freq < target) ? q_ff.freq + 16'h0001
                                                      : q_ff.freq - 16'h0001;
                end else begin
                    nxt_q.acc = acc_sum;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_ff             <= '0;
            q_ff.par.accel   <= RST_TIME;
            q_ff.par.decel   <= RST_TIME;
            q_ff.par.ref_f   <= RST_REF;
            q_ff.par.acc2    <= RST_TIME;
            q_ff.par.dec2    <= NOT_USED;
            q_ff.par.acc3    <= NOT_USED;
            q_ff.par.dec3    <= NOT_USED;
            q_ff.par.base    <= RST_REF;
            q_ff.par.startf  <= RST_STRT;
            q_ff.par.hold    <= NOT_USED;
            q_ff.par.rst_acc <= RST_TIME;
            q_ff.par.gain_a  <= RST_GAIN;
            q_ff.par.gain_b  <= RST_GAIN;
            q_ff.par.inj     <= RST_INJ;
            q_ff.st          <= ST_IDLE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Outputs straight from flip-flops, running_o decoded from the state
    assign rd_data_o   = q_ff.rdata;
    assign ramp_freq_o = q_ff.freq;
    assign ramp_dir_o  = q_ff.dir;
    assign running_o   = (q_ff.st != ST_IDLE);

endmodule

// File: sim/ramp_checker.sv
// Assertions on the ports of freq_ramp.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ns
module ramp_checker
    import ramp_pkg::*;
#(
    parameter int N_TERM = 12
) (
    // Clock, reset and bus
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire ramp_pkg::bus_req_s bus_i,
    input wire logic [31:0]       rd_data_o,
    // Pins and outputs
    input wire logic              start_fwd_i,
    input wire logic              start_rev_i,
    input wire logic              second_set_select_i,
    input wire logic [N_TERM-1:0] term_i,
    input wire logic [15:0]       freq_cmd_i,
    input wire logic [15:0]       ramp_freq_o,
    input wire logic              ramp_dir_o,
    input wire logic              running_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Eight cycles covers the pin filter delay
    sequence halted; (!start_fwd_i && !start_rev_i)[*8]; endsequence
    sequence fwd_start; (start_fwd_i && !start_rev_i)[*4] ##0 $rose(running_o); endsequence
    a_read_quiet: assert property (!$past(bus_i.re) |-> rd_data_o == 32'h0)
        else $error("stray read data");
    a_idle_zero: assert property (!running_o |-> ramp_freq_o == 16'h0)
        else $error("idle output");
    a_step_one: assert property (running_o && $past(running_o) && $past(ramp_freq_o) != 16'h0
        |-> (ramp_freq_o - $past(ramp_freq_o) + 16'h1) <= 16'h2) else $error("step too big");
    a_start_nonzero: assert property ($rose(running_o) |-> ramp_freq_o != 16'h0)
        else $error("start at zero");
    a_start_cause: assert property ($rose(running_o)
        |-> $past(start_fwd_i, 2) != $past(start_rev_i, 2)) else $error("no start");
    a_freq_cap: assert property (ramp_freq_o <= FREQ_MAX) else $error("above ceiling");
    a_stop_falls: assert property (halted |-> ramp_freq_o <= $past(ramp_freq_o))
        else $error("rise while stopped");
    a_dir_fixed: assert property (running_o && $past(running_o) && $past(ramp_freq_o) != 16'h0
        |-> $stable(ramp_dir_o)) else $error("dir flip");
    a_fwd_dir: assert property (fwd_start |-> ramp_dir_o == 1'b0)
        else $error("fwd runs reverse");
endmodule
bind freq_ramp ramp_checker #(.N_TERM(N_TERM)) ramp_checker_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
    .start_fwd_i(start_fwd_i), .start_rev_i(start_rev_i),
    .second_set_select_i(second_set_select_i), .term_i(term_i), .freq_cmd_i(freq_cmd_i),
    .ramp_freq_o(ramp_freq_o), .ramp_dir_o(ramp_dir_o), .running_o(running_o));

// File: sim/panel_model.sv
// Operator panel model: start pins and frequency command.
// Assumes dir requests 0 stop, 1 fwd, 2 rev.
`timescale 1ns/1ns
module panel_model (
    // Clock and requests
    input  wire logic        sys_clk_i,
    input  wire logic [1:0]  dir_req_i,
    input  wire logic [15:0] cmd_req_i,
    // Pins toward the drive
    output logic             start_fwd_o,
    output logic             start_rev_o,
    output logic [15:0]      freq_cmd_o
);
    initial {start_fwd_o, start_rev_o, freq_cmd_o} = '0;
    // Contacts change only after an edge
    always @(posedge sys_clk_i) begin
        start_fwd_o <= dir_req_i == 2'h1;
        start_rev_o <= dir_req_i == 2'h2;
        freq_cmd_o  <= cmd_req_i;
    end
endmodule

// File: sim/test_freq_ramp.sv
// Self-checking bench for freq_ramp.
// Assumes a control tick shortened to 100 clocks.
`timescale 1ns/1ns
module test_freq_ramp;
    import ramp_pkg::*;
    localparam int TK = 100;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    bus_req_s    bus       = '0;
    logic [1:0]  dir_req   = 2'h0;
    logic [15:0] cmd_req   = 16'h0;
    logic        sel2      = 1'b0;
    logic [11:0] term      = 12'h0;
    logic [31:0] rd_data, rdv;
    logic [15:0] freq_cmd, ramp_freq;
    logic        start_fwd, start_rev, ramp_dir, running;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n;
    always #5 sys_clk_i = ~sys_clk_i;
    freq_ramp #(.N_TERM(12), .TICK_COUNT(TK)) freq_ramp_inst (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .bus_i(bus), .rd_data_o(rd_data), .start_fwd_i(start_fwd),
        .start_rev_i(start_rev), .second_set_select_i(sel2), .term_i(term),
        .freq_cmd_i(freq_cmd), .ramp_freq_o(ramp_freq), .ramp_dir_o(ramp_dir),
        .running_o(running));
    panel_model panel_model_inst (.sys_clk_i(sys_clk_i), .dir_req_i(dir_req),
        .cmd_req_i(cmd_req), .start_fwd_o(start_fwd), .start_rev_o(start_rev),
        .freq_cmd_o(freq_cmd));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_win(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_i) bus.we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk_i) bus.re <= 1'b0;
        #1 rdv = rd_data;
    endtask
    task automatic wait_run(input logic lvl, input int lim);
        n = 0;
        while (running !== lvl && n < lim) begin
            @(posedge sys_clk_i) #1 n++;
        end
    endtask
    task automatic wait_freq(input logic [15:0] f, input int lim);
        n = 0;
        while (ramp_freq !== f && n < lim) begin
            @(posedge sys_clk_i) #1 n++;
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0]  ra[7] = '{A_ACC, A_DEC2, A_ACC3, A_HOLD, A_REF, A_STRT, 8'h48};
        logic [15:0] rv[7] = '{16'h0032, 16'h270F, 16'h270F, 16'h270F, 16'h1770, 16'h0032, 16'h0};
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk_val(rdv, {16'h0, rv[i]});
        end
        wr(A_STRT, 32'h1B58);
        rd(A_STRT);
        chk_val(rdv, 32'h1770);
        wr(A_FREQ, 32'h55);
        rd(A_FREQ);
        chk_val(rdv, 32'h0);
        wr(A_STRT, 32'h32);
    endtask
    task automatic t_gate();
        cmd_req <= 16'hA;
        dir_req <= 2'h1;
        repeat (20) @(posedge sys_clk_i);
        chk_val(running, 1'b0);
        wr(A_MINF, 32'h64);
        wait_run(1'b1, 20);
        wait_freq(16'h64, 8000);
        chk_val(ramp_freq, 16'h64);
        dir_req <= 2'h0;
        wait_run(1'b0, 20000);
        wr(A_MINF, 32'h0);
    endtask
    task automatic t_hold();
        wr(A_STRT, 32'h0);
        wr(A_HOLD, 32'h1);
        cmd_req <= 16'h28A;
        dir_req <= 2'h1;
        wait_run(1'b1, 20);
        chk_val(ramp_freq, 16'h1);
        repeat (3000) @(posedge sys_clk_i);
        chk_val(ramp_freq, 16'h1);
        dir_req <= 2'h0;
        wait_run(1'b0, 400);
        chk_val(running, 1'b0);
        wr(A_STRT, 32'h32);
        wr(A_HOLD, 32'h270F);
    endtask
    // Ramp 50 to 650, reference 600: takes the selected time; decel set by hand
    task automatic t_sets();
        logic [3:0]  ct[7] = '{4'h0, 4'h1, 4'h5, 4'h1, 4'h1, 4'h1, 4'h1};
        logic [15:0] a1[7] = '{16'h1, 16'h1, 16'h3, 16'h3, 16'h3, 16'h3, 16'h3};
        logic [15:0] a3[7] = '{16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h5, 16'h270F, 16'h5};
        logic [7:0]  cd[7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h9, 8'h9, 8'h3};
        logic [0:6]  s2    = 7'h0E;
        int          ms[7] = '{100, 10, 40, 20, 50, 20, 20};
        wr(A_REF, 32'h258);
        wr(A_DEC, 32'h1);
        wr(A_ACC2, 32'h2);
        for (int i = 0; i < 7; i++) begin
            wr(A_CTRL, {28'h0, ct[i]});
            wr(A_ACC, {16'h0, a1[i]});
            wr(A_ACC3, {16'h0, a3[i]});
            wr(A_TERM, {24'h0, cd[i]});
            sel2 <= s2[i];
            term <= {11'h0, cd[i] != 8'h0};
            repeat (6) @(posedge sys_clk_i);
            dir_req <= 2'h1;
            wait_run(1'b1, 20);
            chk_val(ramp_freq, 16'h32);
            wait_freq(16'h28A, 20000);
            chk_win(n, ms[i] * TK - TK, ms[i] * TK + 2 * TK);
            dir_req <= 2'h0;
            wait_run(1'b0, 20000);
        end
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_gate();
        t_hold();
        t_sets();
        summarize();
    end
endmodule
